/* File: core/bch_locator_pkg.sv */
// Notes on behaviour
// - Sector-size bit: 0 selects 512-byte sectors, 1 selects 1024-byte sectors.
// - Coefficients live in GF(2^13) for 512-byte, GF(2^14) for 1024-byte sectors.
// - Twenty-five read-write coefficient registers, degrees 0 to 24, 14 bits each.
// - Twenty-three read-only result registers (0x08C to 0x0E4) of 24 positions stored, each holding one error bit position.
// - Reported position zero means the first main-area bit is corrupted.
// - Last sector-area bit reports 4096 (512-byte) or 8192 (1024-byte).
// - First spare bit reports 4097 or 8193, directly after the data positions.
// - Start register holds the 14-bit count of field elements to examine.
// - Writing one to bit 0 of the stop register halts the engine.
// - Status bit 0 shows the engine is busy.
// - Interrupt enable bit 0 enables, interrupt disable bit 0 disables, completion interrupt.
// - Interrupt mask bit 0 shows whether the completion interrupt is enabled.
// - Interrupt status bit 0 flags completion; another field holds the found-error count.
// - Configuration register holds the error degree loaded by software.
// - A read-only register shows the 16-bit field generator polynomial.
// - A write to the start register while idle starts the search; stop register aborts it.
// - Busy stays high for the whole search.
// - At the end: set done, raise interrupt, load count and positions.
package bch_locator_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [8:0] CFG_OFF     = 9'h000;
    localparam logic [8:0] PRIM_OFF    = 9'h004;
    localparam logic [8:0] START_OFF   = 9'h008;
    localparam logic [8:0] STOP_OFF    = 9'h00C;
    localparam logic [8:0] STATUS_OFF  = 9'h010;
    localparam logic [8:0] IEN_OFF     = 9'h014;
    localparam logic [8:0] IDIS_OFF    = 9'h018;
    localparam logic [8:0] IMASK_OFF   = 9'h01C;
    localparam logic [8:0] ISTAT_OFF   = 9'h020;
    localparam logic [8:0] COEFF_FIRST = 9'h028;
    localparam logic [8:0] COEFF_LAST  = 9'h088;
    localparam logic [8:0] POS_FIRST   = 9'h08C;
    localparam logic [8:0] POS_LAST    = 9'h0E4;

    // ----------------------------------------------------------------
    // Fields and sizes
    // ----------------------------------------------------------------
    localparam int unsigned COEFF_COUNT = 25;
    localparam int unsigned POS_COUNT   = 24;
    localparam int unsigned SECTOR_BIT  = 0;
    localparam int unsigned DEGREE_LSB  = 16;
    localparam int unsigned CNT_LSB     = 8;
    localparam int unsigned FLAG_BIT    = 0;
    localparam logic [4:0]  MAX_DEGREE  = 5'h18;

    // ----------------------------------------------------------------
    // Field arithmetic and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] GEN_POLY_13   = 16'h201B;
    localparam logic [15:0] GEN_POLY_14   = 16'h4443;
    localparam logic [13:0] FIELD_MASK_13 = 14'h1FFF;
    localparam logic [13:0] FIELD_MASK_14 = 14'h3FFF;
    localparam logic [13:0] ALPHA         = 14'h0002;
    localparam logic [13:0] FIELD_ONE     = 14'h0001;
    localparam logic [31:0] REG_RESET     = 32'h0000_0000;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [8:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } avmm_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } avmm_rsp_s;

    typedef enum logic [0:0] {ENG_IDLE, ENG_EVAL} engine_state_e;

endpackage : bch_locator_pkg

/* File: core/bch_error_locator_regs.sv */
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module bch_error_locator_regs (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire bch_locator_pkg::avmm_req_s busReq,
    output bch_locator_pkg::avmm_rsp_s      busRsp,
    output logic                            engineIrq
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [13:0]                    coeff   [bch_locator_pkg::COEFF_COUNT];
    logic [13:0]                    posWork [bch_locator_pkg::POS_COUNT];
    logic [13:0]                    errPos  [bch_locator_pkg::POS_COUNT];
    logic                           sectorSel;
    logic [4:0]                     degree;
    logic [15:0]                    primPoly;
    logic [13:0]                    searchLen;
    logic                           haltBit;
    logic                           busy;
    logic                           doneFlag;
    logic                           irqMask;
    logic [4:0]                     errCount;
    logic [4:0]                     foundCount;
    bch_locator_pkg::engine_state_e state;
    logic [13:0]                    element;
    logic [13:0]                    acc;
    logic [13:0]                    index;
    logic [4:0]                     k;

    logic        accept;
    logic        wrAcc;
    logic        rdAcc;
    logic [31:0] beMask;
    logic [31:0] rdWord;
    logic        isCoeff;
    logic        isPos;
    logic [4:0]  coeffIdx;
    logic [4:0]  posIdx;
    logic        startHit;
    logic        haltHit;
    logic [13:0] hornerVal;
    logic        rootHit;
    logic        lastElem;
    logic        finishNow;
    logic [4:0]  degreeClamp;
    logic        next_doneFlag;
    logic        next_irqMask;

    // ----------------------------------------------------------------
    // Field multiply
    // ----------------------------------------------------------------
    // Bit-serial product, unrolled by the loop: all 14 steps combinational, all in a single cycle
    function automatic logic [13:0] gf_mul(input logic [13:0] a, input logic [13:0] b, input logic wide);
        logic [14:0] prod;
        logic [14:0] poly;
        logic [13:0] fmask;
        prod  = '0;
        poly  = wide ? bch_locator_pkg::GEN_POLY_14[14:0] : bch_locator_pkg::GEN_POLY_13[14:0];
        fmask = wide ? bch_locator_pkg::FIELD_MASK_14 : bch_locator_pkg::FIELD_MASK_13;
        for (int i = 13; i >= 0; i--)
        begin
            prod = {prod[13:0], 1'b0};
            if (wide ? prod[14] : prod[13])
            begin
                prod = prod ^ poly;
            end
            if (b[i] && fmask[i])
            begin
                prod = prod ^ {1'b0, a & fmask};
            end
        end
        return prod[13:0] & fmask;
    endfunction : gf_mul

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign accept   = (busReq.read || busReq.write) && !busRsp.waitrequest;
    assign wrAcc    = accept && busReq.write;
    assign rdAcc    = accept && busReq.read;
    assign beMask   = {{8{busReq.byteenable[3]}}, {8{busReq.byteenable[2]}},
                       {8{busReq.byteenable[1]}}, {8{busReq.byteenable[0]}}};
    assign isCoeff  = busReq.address >= bch_locator_pkg::COEFF_FIRST
                      && busReq.address <= bch_locator_pkg::COEFF_LAST && busReq.address[1:0] == 2'b00;
    assign isPos    = busReq.address >= bch_locator_pkg::POS_FIRST
                      && busReq.address <= bch_locator_pkg::POS_LAST && busReq.address[1:0] == 2'b00;
    assign coeffIdx = 5'((busReq.address - bch_locator_pkg::COEFF_FIRST) >> 2);
    assign posIdx   = 5'((busReq.address - bch_locator_pkg::POS_FIRST) >> 2);
    assign startHit = wrAcc && busReq.address == bch_locator_pkg::START_OFF;
    assign haltHit  = wrAcc && busReq.address == bch_locator_pkg::STOP_OFF
                      && busReq.byteenable[0] && busReq.writedata[bch_locator_pkg::FLAG_BIT];

    always_comb
    begin
        rdWord = bch_locator_pkg::REG_RESET;
        if (isCoeff)
        begin
            rdWord[13:0] = coeff[coeffIdx];
        end
        else if (isPos)
        begin
            rdWord[13:0] = errPos[posIdx];
        end
        else
        begin
            unique case (busReq.address)
                bch_locator_pkg::CFG_OFF:
                begin
                    rdWord[bch_locator_pkg::SECTOR_BIT]           = sectorSel;
                    rdWord[bch_locator_pkg::DEGREE_LSB +: 5]      = degree;
                end
                bch_locator_pkg::PRIM_OFF:   rdWord[15:0] = primPoly;
                bch_locator_pkg::START_OFF:  rdWord[13:0] = searchLen;
                bch_locator_pkg::STOP_OFF:   rdWord[bch_locator_pkg::FLAG_BIT] = haltBit;
                bch_locator_pkg::STATUS_OFF: rdWord[bch_locator_pkg::FLAG_BIT] = busy;
                bch_locator_pkg::IMASK_OFF:  rdWord[bch_locator_pkg::FLAG_BIT] = irqMask;
                bch_locator_pkg::ISTAT_OFF:
                begin
                    rdWord[bch_locator_pkg::FLAG_BIT]        = doneFlag;
                    rdWord[bch_locator_pkg::CNT_LSB +: 5]    = errCount;
                end
                default:                     rdWord = bch_locator_pkg::REG_RESET;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Avalon slave answer
    // ----------------------------------------------------------------
    // One wait cycle on every access; read data registered before release
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            busRsp.waitrequest <= 1'b1;
            busRsp.readdata    <= bch_locator_pkg::REG_RESET;
        end
        else
        begin
            busRsp.waitrequest <= !((busReq.read || busReq.write) && busRsp.waitrequest);
            busRsp.readdata    <= busReq.read ? rdWord : bch_locator_pkg::REG_RESET;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Locked while busy so the search never sees a field change mid-way
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sectorSel <= 1'b0;
            degree    <= '0;
            searchLen <= '0;
            haltBit   <= 1'b0;
            for (int i = 0; i < bch_locator_pkg::COEFF_COUNT; i++)
            begin
                coeff[i] <= '0;
            end
        end
        else if (wrAcc && busReq.address == bch_locator_pkg::STOP_OFF && busReq.byteenable[0])
        begin
            haltBit <= busReq.writedata[bch_locator_pkg::FLAG_BIT];
        end
        else if (wrAcc && !busy)
        begin
            if (isCoeff)
            begin
                coeff[coeffIdx] <= (coeff[coeffIdx] & ~beMask[13:0]) | (busReq.writedata[13:0] & beMask[13:0]);
            end
            else if (busReq.address == bch_locator_pkg::CFG_OFF)
            begin
                if (busReq.byteenable[0])
                begin
                    sectorSel <= busReq.writedata[bch_locator_pkg::SECTOR_BIT];
                end
                if (busReq.byteenable[2])
                begin
                    degree <= busReq.writedata[bch_locator_pkg::DEGREE_LSB +: 5];
                end
            end
            else if (busReq.address == bch_locator_pkg::START_OFF)
            begin
                searchLen <= (searchLen & ~beMask[13:0]) | (busReq.writedata[13:0] & beMask[13:0]);
            end
        end
    end

    assign primPoly = sectorSel ? bch_locator_pkg::GEN_POLY_14 : bch_locator_pkg::GEN_POLY_13;

    // ----------------------------------------------------------------
    // Root search engine
    // ----------------------------------------------------------------
    // Horner evaluation of the locator at alpha^index, one term per cycle.
    // Index counts bits in storage order, so positions run on from data into spare.
    assign degreeClamp = (degree > bch_locator_pkg::MAX_DEGREE) ? bch_locator_pkg::MAX_DEGREE : degree;
    assign hornerVal   = gf_mul(acc, element, sectorSel) ^ coeff[k];
    assign rootHit     = state == bch_locator_pkg::ENG_EVAL && k == 5'h00 && hornerVal == 14'h0000;
    assign lastElem    = index == searchLen - 14'h0001;
    assign finishNow   = (state == bch_locator_pkg::ENG_EVAL && k == 5'h00 && lastElem && !haltHit)
                         || (startHit && !busy && busReq.byteenable[1:0] == 2'b11
                             && busReq.writedata[13:0] == 14'h0000);
    assign busy        = state == bch_locator_pkg::ENG_EVAL;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state      <= bch_locator_pkg::ENG_IDLE;
            element    <= '0;
            acc        <= '0;
            index      <= '0;
            k          <= '0;
            foundCount <= '0;
        end
        else if (haltHit)
        begin
            state <= bch_locator_pkg::ENG_IDLE;
        end
        else if (startHit && !busy)
        begin
            state      <= finishNow ? bch_locator_pkg::ENG_IDLE : bch_locator_pkg::ENG_EVAL;
            element    <= bch_locator_pkg::FIELD_ONE;
            acc        <= '0;
            index      <= '0;
            k          <= degreeClamp;
            foundCount <= '0;
        end
        else if (state == bch_locator_pkg::ENG_EVAL)
        begin
            if (k != 5'h00)
            begin
                acc <= hornerVal;
                k   <= k - 5'h01;
            end
            else
            begin
                if (rootHit && foundCount < 5'(bch_locator_pkg::POS_COUNT))
                begin
                    foundCount <= foundCount + 5'h01;
                end
                if (lastElem)
                begin
                    state <= bch_locator_pkg::ENG_IDLE;
                end
                else
                begin
                    element <= gf_mul(element, bch_locator_pkg::ALPHA, sectorSel);
                    index   <= index + 14'h0001;
                    acc     <= '0;
                    k       <= degreeClamp;
                end
            end
        end
    end

    // Working positions, copied out only when the search completes
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < bch_locator_pkg::POS_COUNT; i++)
            begin
                posWork[i] <= '0;
            end
        end
        else if (startHit && !busy)
        begin
            for (int i = 0; i < bch_locator_pkg::POS_COUNT; i++)
            begin
                posWork[i] <= '0;
            end
        end
        else if (rootHit && foundCount < 5'(bch_locator_pkg::POS_COUNT))
        begin
            posWork[foundCount] <= index;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            errCount <= '0;
            for (int i = 0; i < bch_locator_pkg::POS_COUNT; i++)
            begin
                errPos[i] <= '0;
            end
        end
        else if (finishNow)
        begin
            errCount <= (state != bch_locator_pkg::ENG_EVAL) ? 5'h00
                        : foundCount + 5'(rootHit && foundCount < 5'(bch_locator_pkg::POS_COUNT));
            for (int i = 0; i < bch_locator_pkg::POS_COUNT; i++)
            begin
                errPos[i] <= (state != bch_locator_pkg::ENG_EVAL) ? 14'h0000
                             : (rootHit && foundCount == 5'(i)) ? index : posWork[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Completion flag and interrupt
    // ----------------------------------------------------------------
    always_comb
    begin
        next_doneFlag = doneFlag;
        if (rdAcc && busReq.address == bch_locator_pkg::ISTAT_OFF)
        begin
            next_doneFlag = 1'b0;
        end
        if (finishNow)
        begin
            next_doneFlag = 1'b1;
        end
        next_irqMask = irqMask;
        if (wrAcc && busReq.byteenable[0] && busReq.writedata[bch_locator_pkg::FLAG_BIT])
        begin
            if (busReq.address == bch_locator_pkg::IEN_OFF)
            begin
                next_irqMask = 1'b1;
            end
            else if (busReq.address == bch_locator_pkg::IDIS_OFF)
            begin
                next_irqMask = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            doneFlag  <= 1'b0;
            irqMask   <= 1'b0;
            engineIrq <= 1'b0;
        end
        else
        begin
            doneFlag  <= next_doneFlag;
            irqMask   <= next_irqMask;
            engineIrq <= next_doneFlag && next_irqMask;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_start_busy: assert property (@(posedge clk) disable iff (reset)
        startHit && !busy && !finishNow |=> busy && state == bch_locator_pkg::ENG_EVAL)
        else $error("start write did not raise busy");

    a_halt_stop: assert property (@(posedge clk) disable iff (reset)
        haltHit |=> !busy && doneFlag == $past(doneFlag))
        else $error("halt did not stop the engine");

    a_busy_hold: assert property (@(posedge clk) disable iff (reset)
        busy && !haltHit && !(k == 5'h00 && lastElem) |=> busy)
        else $error("busy dropped during search");

    a_finish_done: assert property (@(posedge clk) disable iff (reset)
        finishNow |=> doneFlag && !busy && errCount <= bch_locator_pkg::MAX_DEGREE)
        else $error("completion not reported");

    a_irq_masked: assert property (@(posedge clk) disable iff (reset)
        !next_irqMask |=> !engineIrq)
        else $error("interrupt raised while masked");

    a_irq_done: assert property (@(posedge clk) disable iff (reset)
        doneFlag && irqMask |-> engineIrq)
        else $error("interrupt missing with done and mask set");

    a_mask_enable: assert property (@(posedge clk) disable iff (reset)
        wrAcc && busReq.address == bch_locator_pkg::IEN_OFF && busReq.byteenable[0] && busReq.writedata[0]
        |=> irqMask)
        else $error("interrupt enable write ignored");

    a_coeff_store: assert property (@(posedge clk) disable iff (reset)
        wrAcc && !busy && busReq.address == bch_locator_pkg::COEFF_FIRST && busReq.byteenable == 4'hF
        |=> coeff[0] == $past(busReq.writedata[13:0]))
        else $error("coefficient write lost");

    a_pos_range: assert property (@(posedge clk) disable iff (reset)
        rootHit |-> index < searchLen)
        else $error("position beyond search length");

    a_wait_pulse: assert property (@(posedge clk) disable iff (reset)
        !busRsp.waitrequest |=> busRsp.waitrequest)
        else $error("waitrequest low for more than one cycle");

endmodule : bch_error_locator_regs

/* File: sim/tb_bch_error_locator_regs.sv */
`timescale 1ns/1ps
module tb_bch_error_locator_regs;
    logic                       clk = 1'b0;
    logic                       reset = 1'b1;
    bch_locator_pkg::avmm_req_s busReq = '0;
    bch_locator_pkg::avmm_rsp_s busRsp;
    logic                       engineIrq;
    logic [31:0]                rd;
    int                         num_errors = 0;
    int                         n_tests = 0;
    logic [8:0]                 zeroRegs [11] = '{9'h000, 9'h008, 9'h00C, 9'h010, 9'h01C, 9'h020,
                                                  9'h028, 9'h088, 9'h08C, 9'h0E4, 9'h024};

    bch_error_locator_regs DUT (.clk(clk), .reset(reset), .busReq(busReq), .busRsp(busRsp), .engineIrq(engineIrq));

    initial forever #10 clk = ~clk;

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Idle cycle after each access keeps the strobe from toggling twice in one step
    task automatic bus_acc(input logic w, input logic [8:0] a, input logic [31:0] d);
        busReq.write      <= w;
        busReq.read       <= ~w;
        busReq.address    <= a;
        busReq.writedata  <= d;
        busReq.byteenable <= 4'hF;
        do @(posedge clk); while (busRsp.waitrequest !== 1'b0);
        rd = busRsp.readdata;
        busReq.write <= 1'b0;
        busReq.read  <= 1'b0;
        @(posedge clk);
    endtask : bus_acc

    task automatic rdchk(input logic [8:0] a, input logic [31:0] e, input string n);
        bus_acc(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rdchk

    // Field power by shift-and-reduce, independent of the engine's own arithmetic
    function automatic logic [13:0] alpha_pow(input int i, input logic big);
        logic [15:0] v;
        v = 16'h0001;
        repeat (i)
        begin
            v = v << 1;
            if (big ? v[14] : v[13])
                v = v ^ (big ? 16'h4443 : 16'h201B);
        end
        return v[13:0];
    endfunction : alpha_pow

    // Degree-1 locator x + r has its single root at the wanted position
    task automatic run_search(input logic big, input int pos, input int len);
        int n;
        n = 0;
        bus_acc(1'b1, 9'h000, {11'h0, 5'h01, 15'h0, big});
        bus_acc(1'b1, 9'h028, {18'h0, alpha_pow(pos, big)});
        bus_acc(1'b1, 9'h02C, 32'h1);
        bus_acc(1'b1, 9'h008, len);
        rdchk(9'h010, 32'h1, "busy");
        while (engineIrq !== 1'b1 && n < 20000)
        begin
            @(posedge clk);
            n++;
            if (n % 500 == 0 && n < 2 * len - 10)
                rdchk(9'h010, 32'h1, "busyLen");
        end
        chk("irq", 32'h1, engineIrq);
        rdchk(9'h010, 32'h0, "idle");
        rdchk(9'h020, 32'h0000_0101, "istat");
        rdchk(9'h08C, pos, "position");
        @(posedge clk);
        chk("irqClr", 32'h0, engineIrq);
        $display("test search pos %0d sector %0d ended", pos, big);
    endtask : run_search

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        foreach (zeroRegs[i]) rdchk(zeroRegs[i], 32'h0, "resetVal");
        rdchk(9'h004, 32'h0000_201B, "prim13");
        bus_acc(1'b1, 9'h088, 32'hFFFF_FFFF);
        rdchk(9'h088, 32'h0000_3FFF, "coeff24");
        bus_acc(1'b1, 9'h0E4, 32'h0000_1234);
        rdchk(9'h0E4, 32'h0, "posRo");
        bus_acc(1'b1, 9'h014, 32'h1);
        rdchk(9'h01C, 32'h1, "maskOn");
        $display("test registers ended");
        run_search(1'b0, 0, 3);
        run_search(1'b0, 4096, 4098);
        run_search(1'b0, 4097, 4122);
        run_search(1'b1, 8193, 8220);
        rdchk(9'h004, 32'h0000_4443, "prim14");
        rdchk(9'h000, 32'h0001_0001, "config");
        bus_acc(1'b1, 9'h008, 32'd4000);
        bus_acc(1'b1, 9'h028, 32'h5);
        bus_acc(1'b1, 9'h00C, 32'h1);
        rdchk(9'h010, 32'h0, "halted");
        rdchk(9'h020, 32'h0000_0100, "noDone");
        rdchk(9'h028, alpha_pow(8193, 1'b1), "locked");
        bus_acc(1'b1, 9'h008, 32'h0);
        rdchk(9'h020, 32'h0000_0001, "zeroLen");
        rdchk(9'h08C, 32'h0, "zeroPos");
        bus_acc(1'b1, 9'h018, 32'h1);
        rdchk(9'h01C, 32'h0, "maskOff");
        $display("test halt and mask ended");
        give_verdict();
    end

    initial
    begin
        #1_500_000;
        num_errors++;
        give_verdict();
    end
endmodule : tb_bch_error_locator_regs
